// ==== logic/fcra_pkg.sv ====
// shared constants, command codes, bus timing and carrier types of the flash host
// assumes a 25 MHz clk and a byte-wide parallel flash with a command register
package fcra_pkg;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   // command bytes written to the flash command register
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_RESET = 8'hFF;
   localparam logic [7:0] CMD_PROG = 8'h10;
   localparam logic [7:0] CMD_ERASE = 8'h30;
   localparam logic [7:0] CMD_IDENT = 8'h90;
   // status bit positions in a polled byte
   localparam int BIT_POLL = 7;
   localparam int BIT_TOGGLE = 6;
   localparam int BIT_TIMEOUT = 5;
   // identification read addresses
   localparam logic [ADDR_W-1:0] ID_MFR_ADDR = 15'h0000;
   localparam logic [ADDR_W-1:0] ID_DEV_ADDR = 15'h0001;
   // bus timing: least times round up to whole clk cycles
   localparam int CLK_NS = 40;
   localparam int T_WP_NS = 60;
   localparam int T_ACC_NS = 150;
   localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYNC_LAT = 4;
   localparam logic [3:0] PH_WE_END = 4'(WP_CYC);
   localparam logic [3:0] PH_RD_END = 4'(ACC_CYC + SYNC_LAT);

   typedef enum logic [2:0] {
      OP_READ = 3'h0,
      OP_PROG = 3'h1,
      OP_ERASE = 3'h2,
      OP_IDENT = 3'h3,
      OP_RESET = 3'h4
   } fcra_op_e;

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_W1 = 8'h02,
      ST_W2 = 8'h04,
      ST_P1 = 8'h08,
      ST_P2 = 8'h10,
      ST_RD = 8'h20,
      ST_W3 = 8'h40,
      ST_END = 8'h80
   } fcra_state_e;

   typedef struct packed {
      fcra_op_e op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fcra_cmd_s;

   typedef struct packed {
      logic ce_b;
      logic oe_b;
      logic we_b;
      logic dq_oe;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq;
   } fcra_pins_s;

   typedef struct packed {
      logic fail;
      logic [DATA_W-1:0] data;
   } fcra_rsp_s;
endpackage

// ==== logic/fcra_sync.sv ====
// three-stage input synchroniser for the flash data pins
// assumes din is asynchronous to clk; dout changes once stages two and three agree
module fcra_sync import fcra_pkg::*; #(
   parameter int W = 8
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce_en,
   // data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // first stage feeds only the second, to keep metastability contained
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else if (ce_en) begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // accept a value only when it held for two samples
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dout <= '0;
      end else if (ce_en && (s2_q == s3_q)) begin
         dout <= s3_q;
      end
   end
endmodule

// ==== logic/fcra_host.sv ====
// host sequencer that drives a byte-wide command-register flash through its pins
// assumes flash pins attach directly; dq_i is asynchronous and resynchronised here
module fcra_host import fcra_pkg::*; (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce_en,
   // user command port
   input wire logic cmd_valid,
   input wire fcra_cmd_s cmd,
   output logic cmd_ready,
   output logic rsp_valid,
   output fcra_rsp_s rsp,
   output logic dev_failed,
   // flash pins
   output fcra_pins_s pins,
   input wire logic [DATA_W-1:0] dq_i
);
   fcra_state_e st_q;
   fcra_op_e op_q;
   logic [ADDR_W-1:0] adr_q;
   logic [DATA_W-1:0] dat_q;
   logic [DATA_W-1:0] wdat_q;
   logic [DATA_W-1:0] s1_q;
   logic go_q;
   logic wr_q;
   logic bact_q;
   logic done_q;
   logic [3:0] ph_q;
   logic [DATA_W-1:0] rd_q;
   logic [DATA_W-1:0] dq_s;
   logic take;

   ////////////////////////////////////////////////////////////////////////
   // input path

   fcra_sync #(.W(DATA_W)) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .ce_en(ce_en),
      .din(dq_i),
      .dout(dq_s)
   );

   assign take = cmd_valid && cmd_ready;

   // decides when a polled pair of status bytes shows completion
   function automatic logic op_done(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
      op_done = (a[BIT_TOGGLE] == b[BIT_TOGGLE]);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // bus cycle engine: one write or read cycle per go pulse

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pins <= '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, dq_oe: 1'b0, addr: '0, dq: '0};
         bact_q <= 1'b0;
         done_q <= 1'b0;
         ph_q <= 4'h0;
         rd_q <= '0;
      end else if (ce_en) begin
         done_q <= 1'b0;
         if (!bact_q && go_q) begin
            // address and data set up a cycle ahead of the strobe
            bact_q <= 1'b1;
            ph_q <= 4'h0;
            pins.ce_b <= 1'b0;
            pins.addr <= adr_q;
            pins.dq <= wdat_q;
            pins.dq_oe <= wr_q;
         end else if (bact_q) begin
            ph_q <= ph_q + 4'h1;
            if (wr_q) begin
               if (ph_q == 4'h0) begin
                  pins.we_b <= 1'b0;
               end
               if (ph_q == PH_WE_END) begin
                  pins.we_b <= 1'b1;
               end
               // data held one cycle past the rising strobe
               if (ph_q == PH_WE_END + 4'h1) begin
                  pins.ce_b <= 1'b1;
                  pins.dq_oe <= 1'b0;
                  bact_q <= 1'b0;
                  done_q <= 1'b1;
               end
            end else begin
               if (ph_q == 4'h0) begin
                  pins.oe_b <= 1'b0;
               end
               // sample late enough to cover access time and synchroniser
               if (ph_q == PH_RD_END) begin
                  rd_q <= dq_s;
                  pins.oe_b <= 1'b1;
                  pins.ce_b <= 1'b1;
                  bact_q <= 1'b0;
                  done_q <= 1'b1;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command sequencer

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_q <= ST_IDLE;
         op_q <= OP_READ;
         adr_q <= '0;
         dat_q <= '0;
         wdat_q <= '0;
         wr_q <= 1'b0;
         go_q <= 1'b0;
         s1_q <= '0;
         rsp <= '0;
      end else if (ce_en) begin
         go_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (take) begin
                  op_q <= cmd.op;
                  dat_q <= cmd.data;
                  rsp <= '0;
                  adr_q <= cmd.addr;
                  go_q <= 1'b1;
                  if (dev_failed && cmd.op != OP_READ) begin
                     rsp.fail <= 1'b1;
                     go_q <= 1'b0;
                     st_q <= ST_END;
                  end else if (cmd.op == OP_READ) begin
                     wr_q <= 1'b0;
                     st_q <= ST_RD;
                  end else begin
                     wr_q <= 1'b1;
                     st_q <= ST_W1;
                     case (cmd.op)
                        OP_PROG: wdat_q <= CMD_PROG;
                        OP_ERASE: wdat_q <= CMD_ERASE;
                        OP_IDENT: wdat_q <= CMD_IDENT;
                        default: wdat_q <= CMD_RESET;
                     endcase
                  end
               end
            end
            ST_W1: begin
               if (done_q) begin
                  go_q <= 1'b1;
                  if (op_q == OP_IDENT) begin
                     wr_q <= 1'b0;
                     adr_q <= adr_q[0] ? ID_DEV_ADDR : ID_MFR_ADDR;
                     st_q <= ST_RD;
                  end else begin
                     st_q <= ST_W2;
                     case (op_q)
                        OP_PROG: wdat_q <= dat_q;
                        OP_ERASE: wdat_q <= CMD_ERASE;
                        default: wdat_q <= CMD_RESET;
                     endcase
                  end
               end
            end
            ST_W2: begin
               if (done_q) begin
                  if (op_q == OP_RESET) begin
                     st_q <= ST_END;
                  end else begin
                     wr_q <= 1'b0;
                     go_q <= 1'b1;
                     st_q <= ST_P1;
                  end
               end
            end
            ST_P1: begin
               if (done_q) begin
                  s1_q <= rd_q;
                  go_q <= 1'b1;
                  st_q <= ST_P2;
               end
            end
            ST_P2: begin
               if (done_q) begin
                  if (op_done(s1_q, rd_q)) begin
                     rsp.data <= rd_q;
                     if (op_q == OP_PROG) begin
                        rsp.fail <= (rd_q[BIT_POLL] != dat_q[BIT_POLL]);
                     end else begin
                        rsp.fail <= !rd_q[BIT_POLL];
                     end
                     if (op_q == OP_ERASE) begin
                        wr_q <= 1'b1;
                        wdat_q <= CMD_READ;
                        go_q <= 1'b1;
                        st_q <= ST_W3;
                     end else begin
                        st_q <= ST_END;
                     end
                  end else if (rd_q[BIT_TIMEOUT] && s1_q[BIT_TIMEOUT]) begin
                     // timeout seen twice, stop issuing commands other than reads
                     rsp.fail <= 1'b1;
                     rsp.data <= rd_q;
                     st_q <= ST_END;
                  end else begin
                     s1_q <= rd_q;
                     go_q <= 1'b1;
                  end
               end
            end
            ST_RD: begin
               if (done_q) begin
                  rsp.data <= rd_q;
                  if (op_q == OP_IDENT) begin
                     wr_q <= 1'b1;
                     wdat_q <= CMD_RESET;
                     go_q <= 1'b1;
                     st_q <= ST_W3;
                  end else begin
                     st_q <= ST_END;
                  end
               end
            end
            ST_W3: begin
               if (done_q) begin
                  st_q <= ST_END;
               end
            end
            ST_END: begin
               st_q <= ST_IDLE;
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // handshake and sticky failure

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
      end else if (ce_en) begin
         cmd_ready <= (st_q == ST_END) || (st_q == ST_IDLE && !take);
         rsp_valid <= (st_q == ST_END);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dev_failed <= 1'b0;
      end else if (ce_en && st_q == ST_P2 && done_q && !op_done(s1_q, rd_q)
                   && rd_q[BIT_TIMEOUT] && s1_q[BIT_TIMEOUT]) begin
         dev_failed <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   strobe_excl_a: assert property (@(posedge clk) disable iff (!rst_b) !(!pins.we_b && !pins.oe_b))
      else $error("write and output enable low together");
   erase_twice_a: assert property (@(posedge clk) disable iff (!rst_b)
      (st_q == ST_W2 && op_q == OP_ERASE && go_q) |-> wdat_q == CMD_ERASE ##1 pins.dq == CMD_ERASE)
      else $error("erase not confirmed with erase code");
   reset_twice_a: assert property (@(posedge clk) disable iff (!rst_b)
      (st_q == ST_W2 && op_q == OP_RESET && $rose(go_q)) |-> ##1 (pins.dq == CMD_RESET && pins.dq_oe))
      else $error("second reset write missing");
   ident_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
      (st_q == ST_W1 && op_q == OP_IDENT && go_q) |-> wdat_q == CMD_IDENT)
      else $error("identification command wrong");
   ident_exit_a: assert property (@(posedge clk) disable iff (!rst_b)
      (st_q == ST_W3 && op_q == OP_IDENT && go_q) |-> wdat_q == CMD_RESET && wr_q)
      else $error("identification not left with reset");
   erase_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
      (st_q == ST_W3 && op_q == OP_ERASE && go_q) |-> wdat_q == CMD_READ)
      else $error("finished erase not masked");
   timeout_fail_a: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(dev_failed) |-> ##1 (st_q == ST_IDLE && rsp_valid && rsp.fail))
      else $error("timeout not reported as failure");
   fail_refuse_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce_en && dev_failed && take && cmd.op != OP_READ) |=> (st_q == ST_END && !go_q))
      else $error("failed device still commanded");
   rsp_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
      (rsp_valid && ce_en) |=> !rsp_valid)
      else $error("response longer than one cycle");

   erase_done_c: cover property (@(posedge clk) disable iff (!rst_b)
      st_q == ST_W3 && op_q == OP_ERASE && done_q);
   ident_done_c: cover property (@(posedge clk) disable iff (!rst_b)
      rsp_valid && op_q == OP_IDENT);
   fail_seen_c: cover property (@(posedge clk) disable iff (!rst_b) $rose(dev_failed));
endmodule

// ==== verification/fcra_flash_model.sv ====
// behavioural byte-wide command-register flash standing behind the host
// assumes pins come straight from the host; dq_o is merged with the host drive outside
module fcra_flash_model import fcra_pkg::*; #(
   parameter logic [7:0] MFR_CODE = 8'h5C, // arbitrary value
   parameter logic [7:0] DEV_CODE = 8'hC3, // arbitrary value
   parameter int BUSY_POLLS = 3
) (
   // host pins
   input wire fcra_pins_s pins,
   // bench controls
   input wire logic pwr_rst,
   input wire logic fail_en,
   // data out and write count
   output logic [7:0] dq_o,
   output int n_writes
);
   timeunit 1ns;
   timeprecision 1ps;
   typedef enum logic [2:0] {M_READ, M_IDENT, M_PSET, M_ESET, M_BUSY, M_FAIL} fcra_mode_e;
   fcra_mode_e mode;
   logic [7:0] mem [32];
   logic [7:0] pdata;
   logic [7:0] last;
   logic [4:0] paddr;
   logic tog;
   logic erasing;
   int left;

   ////////////////////////////////////////////////////////////////////////////////
   // erased array at start; a later power-up never touches the cells
   initial begin
      foreach (mem[i]) mem[i] = 8'hFF;
      n_writes = 0;
      tog = 1'b0;
      erasing = 1'b0;
      pdata = 8'h00;
      last = 8'h00;
      dq_o = 8'hFF;
      mode = M_READ;
   end
   always @(posedge pwr_rst) mode = M_READ;

   ////////////////////////////////////////////////////////////////////////////////
   // write decode on the closing edge of the write strobe
   always @(posedge pins.we_b) begin
      if (!pins.ce_b) begin
         n_writes++;
         case (mode)
            M_FAIL: ;
            // write after setup is data, ones program nothing
            M_PSET: begin
               pdata = pins.dq;
               paddr = pins.addr[4:0];
               erasing = 1'b0;
               left = BUSY_POLLS;
               mode = M_BUSY;
            end
            // second erase code starts the erase
            M_ESET: begin
               erasing = 1'b1;
               left = BUSY_POLLS;
               mode = (pins.dq == CMD_ERASE) ? M_BUSY : M_READ;
            end
            // command decode, anything else aborts to read
            default: case (pins.dq)
               8'h10, 8'h50: mode = M_PSET;
               8'h30: mode = M_ESET;
               8'h80, 8'h90: mode = M_IDENT;
               default: mode = M_READ;
            endcase
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read answers on the opening edge of the output enable
   always @(negedge pins.oe_b) begin
      if (!pins.ce_b) begin
         case (mode)
            M_BUSY: begin
               tog = ~tog;
               if (fail_en) mode = M_FAIL;
               if (left == 0 && !fail_en) begin
                  // cells change only on completion, so an abort alters nothing
                  if (erasing) foreach (mem[i]) mem[i] = 8'hFF;
                  else mem[paddr] = mem[paddr] & pdata;
                  mode = M_READ;
                  last = mem[pins.addr[4:0]];
               end else begin
                  last = {erasing ? 1'b0 : ~pdata[7], tog, fail_en, 5'h00};
                  left--;
               end
            end
            // only polling remains after a timeout
            M_FAIL: begin
               tog = ~tog;
               last = {erasing ? 1'b0 : ~pdata[7], tog, 1'b1, 5'h00};
            end
            M_IDENT: last = (pins.addr == ID_MFR_ADDR) ? MFR_CODE :
               (pins.addr == ID_DEV_ADDR) ? DEV_CODE : mem[pins.addr[4:0]];
            default: last = mem[pins.addr[4:0]];
         endcase
         dq_o = last;
      end
   end
   // released bus shows the inverse so a stale byte never passes for data
   always @(posedge pins.oe_b) dq_o = ~last;
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the flash host sequencer against a behavioural flash
// assumes the host drives pins registered on clk and answers each command once
`define FCRA_CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench import fcra_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] MFR_CODE = 8'h5C; // arbitrary value
   localparam logic [7:0] DEV_CODE = 8'hC3; // arbitrary value
   typedef struct {
      fcra_op_e op;
      logic [14:0] addr;
      logic [7:0] data;
      logic fail;
      logic [7:0] rdata;
      logic chk;
      int wr;
   } fcra_row_s;
   logic clk, rst_b, ce_en, cmd_valid, cmd_ready, rsp_valid, dev_failed, pwr_rst, fail_en;
   fcra_cmd_s cmd;
   fcra_rsp_s rsp;
   fcra_pins_s pins;
   logic [7:0] dq_wire, flash_dq;
   int flash_writes, got_writes, n_errors, cmp_count;
   int cyc = 0;
   // op, address, data, fail, answer, answer checked, writes seen by the flash
   fcra_row_s rows [12] = '{
      '{OP_READ, 15'h0003, 8'h00, 1'b0, 8'hFF, 1'b1, 0},
      '{OP_PROG, 15'h0003, 8'hA5, 1'b0, 8'hA5, 1'b1, 2},
      '{OP_READ, 15'h0003, 8'h00, 1'b0, 8'hA5, 1'b1, 0},
      '{OP_IDENT, 15'h0000, 8'h00, 1'b0, MFR_CODE, 1'b1, 2},
      '{OP_IDENT, 15'h0001, 8'h00, 1'b0, DEV_CODE, 1'b1, 2},
      '{OP_READ, 15'h0003, 8'h00, 1'b0, 8'hA5, 1'b1, 0},
      '{OP_RESET, 15'h0000, 8'h00, 1'b0, 8'h00, 1'b0, 2},
      '{OP_READ, 15'h0003, 8'h00, 1'b0, 8'hA5, 1'b1, 0},
      '{OP_ERASE, 15'h0003, 8'h00, 1'b0, 8'hFF, 1'b1, 3},
      '{OP_READ, 15'h0003, 8'h00, 1'b0, 8'hFF, 1'b1, 0},
      '{OP_PROG, 15'h0007, 8'h3C, 1'b0, 8'h3C, 1'b1, 2},
      '{OP_READ, 15'h0007, 8'h00, 1'b0, 8'h3C, 1'b1, 0}
   };

   ////////////////////////////////////////////////////////////////////////////////
   fcra_host i_fcra_host (.clk(clk), .rst_b(rst_b), .ce_en(ce_en), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .dev_failed(dev_failed), .pins(pins),
      .dq_i(dq_wire));
   fcra_flash_model #(.MFR_CODE(MFR_CODE), .DEV_CODE(DEV_CODE), .BUSY_POLLS(3)) i_fcra_flash_model (
      .pins(pins), .pwr_rst(pwr_rst), .fail_en(fail_en), .dq_o(flash_dq), .n_writes(flash_writes));
   // shared data wire: host drive wins while its enable is up
   assign dq_wire = pins.dq_oe ? pins.dq : flash_dq;
   // free-running 25 MHz clock
   always #20 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   // cycle ceiling well above the whole sequence, so a hang still ends the run
   always @(posedge clk) begin
      cyc++;
      if (cyc >= 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   // counts, then the verdict
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // one command, entered and left at a falling edge; back to back is allowed
   task automatic run_cmd(input fcra_op_e op, input logic [14:0] a, input logic [7:0] d);
      int w0;
      w0 = flash_writes;
      cmd.op = op;
      cmd.addr = a;
      cmd.data = d;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1) @(negedge clk);
      got_writes = flash_writes - w0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      ce_en = 1'b1;
      cmd_valid = 1'b0;
      cmd = '0;
      pwr_rst = 1'b1;
      fail_en = 1'b0;
      n_errors = 0;
      cmp_count = 0;
      repeat (10) @(negedge clk);
      `FCRA_CHK({pins.ce_b, pins.oe_b, pins.we_b, pins.dq_oe, cmd_ready, dev_failed}, 6'b111000)
      rst_b = 1'b1;
      pwr_rst = 1'b0;
      @(negedge clk);
      // ordinary cases from the table
      foreach (rows[i]) begin
         run_cmd(rows[i].op, rows[i].addr, rows[i].data);
         `FCRA_CHK(rsp.fail, rows[i].fail)
         if (rows[i].chk) `FCRA_CHK(rsp.data, rows[i].rdata)
         `FCRA_CHK(got_writes, rows[i].wr)
      end
      // clock enable dropped in the middle of a read
      fork
         run_cmd(OP_READ, 15'h0007, 8'h00);
         begin
            repeat (6) @(negedge clk);
            ce_en = 1'b0;
            repeat (5) @(negedge clk);
            ce_en = 1'b1;
         end
      join
      `FCRA_CHK(rsp.data, 8'h3C)
      // the part never finishes a program and flags the timeout
      fail_en = 1'b1;
      run_cmd(OP_PROG, 15'h0009, 8'h00);
      `FCRA_CHK({rsp.fail, dev_failed}, 2'b11)
      run_cmd(OP_ERASE, 15'h0000, 8'h00);
      `FCRA_CHK(rsp.fail, 1'b1)
      `FCRA_CHK(got_writes, 0)
      run_cmd(OP_READ, 15'h0009, 8'h00);
      `FCRA_CHK(rsp.data[BIT_TIMEOUT], 1'b1)
      `FCRA_CHK(got_writes, 0)
      // host reset plus a fresh power-up clear the failure, cells kept
      @(negedge clk);
      rst_b = 1'b0;
      pwr_rst = 1'b1;
      fail_en = 1'b0;
      @(negedge clk);
      `FCRA_CHK({dev_failed, cmd_ready, pins.ce_b}, 3'b001)
      rst_b = 1'b1;
      pwr_rst = 1'b0;
      run_cmd(OP_READ, 15'h0007, 8'h00);
      `FCRA_CHK(rsp.data, 8'h3C)
      `FCRA_CHK(got_writes, 0)
      report_and_stop();
   end
endmodule
